// ---- common/isa_feature_defines.vh ----
// Purpose: Constants for the instruction-set feature identification registers
// Assumes: Coprocessor register selectors are 4 bits, opcodes 3 bits
// Notes: Definitions only
`ifndef ISA_FEATURE_DEFINES_VH
`define ISA_FEATURE_DEFINES_VH

// ********************************************
// Field positions (low bit of each nibble)
// ********************************************
`define FLD_BYTECODE_LSB 5'd28
`define FLD_INTERWORK_LSB 5'd24
`define FLD_IMMEDIATE_LSB 5'd20
`define FLD_COND_BLOCK_LSB 5'd16
`define FLD_EXTEND_LSB 5'd12
`define FLD_PROFILE_EXC_LSB 5'd8
`define FLD_EXCEPT_LSB 5'd4
`define FLD_ENDIAN_LSB 5'd0

// ********************************************
// Fixed field values
// ********************************************
`define VAL_BYTECODE 4'h1
`define VAL_INTERWORK 4'h3
`define VAL_IMMEDIATE 4'h1
`define VAL_COND_BLOCK 4'h1
`define VAL_EXTEND 4'h2
`define VAL_PROFILE_EXC 4'h1
`define VAL_EXCEPT 4'h1
`define VAL_ENDIAN 4'h1

// ********************************************
// Coprocessor access encodings
// ********************************************
`define SEL_OPC1 3'h0
`define SEL_CRN 4'h0
`define SEL_CRM 4'h2
`define SEL_OPC2_ATTR_TWO 3'h1
`define SEL_OPC2_ATTR_THREE 3'h2

// Unprivileged mode level
`define PRIV_USER 2'h0

`endif

// ---- verilog/attr_two_value.v ----
// Purpose: Builds the fixed word of the second attribute register
// Assumes: Nothing; pure constant logic
// Notes: Nibble placement is driven by the defines
`timescale 1ns/10ps
`include "isa_feature_defines.vh"
module attr_two_value (
    // Result
    output wire [31:0] value
);
    assign value = ({28'h0000000, `VAL_BYTECODE} << `FLD_BYTECODE_LSB)
                 | ({28'h0000000, `VAL_INTERWORK} << `FLD_INTERWORK_LSB)
                 | ({28'h0000000, `VAL_IMMEDIATE} << `FLD_IMMEDIATE_LSB)
                 | ({28'h0000000, `VAL_COND_BLOCK} << `FLD_COND_BLOCK_LSB)
                 | ({28'h0000000, `VAL_EXTEND} << `FLD_EXTEND_LSB)
                 | ({28'h0000000, `VAL_PROFILE_EXC} << `FLD_PROFILE_EXC_LSB)
                 | ({28'h0000000, `VAL_EXCEPT} << `FLD_EXCEPT_LSB)
                 | ({28'h0000000, `VAL_ENDIAN} << `FLD_ENDIAN_LSB);
endmodule

// ---- verilog/attr_three_value.v ----
// Purpose: Supplies the third attribute register word
// Assumes: Field layout is a build-time parameter
// Notes: Same word in both security states
`timescale 1ns/10ps
module attr_three_value #(
    parameter [31:0] RESET_VALUE = 32'h00000000
) (
    // Result
    output wire [31:0] value
);
    assign value = RESET_VALUE;
endmodule

// ---- verilog/isa_feature_regs.v ----
// Purpose: Read-only instruction-set feature identification registers
// Assumes: Requests arrive as one-cycle coprocessor access strobes on clk
// Notes: Answer one cycle after request; writes and faults leave contents intact
`timescale 1ns/10ps
`include "isa_feature_defines.vh"

// Behaviour
// - Bits 31:28 of second attribute register read 0x1.
// - Bits 27:24 read 3, interworking support.
// - Bits 23:20 read 1, long immediate support.
// - Bits 19:16 read 0x1, conditional block support.
// - Bits 15:12 read 0x2, extend instructions.
// - Bits 11:8 read 1, profile exception instructions.
// - Bits 7:4 read 1, exception return instructions.
// - Bits 3:0 read 0x1, endianness instruction support.
// - Read at privilege level one or above with opcode1 0, c0, c2, opcode2 1 returns that word.
// - Third register read-only, same in both security states.
// - Third register refused below privilege level one.
module isa_feature_regs #(
    parameter [31:0] ATTR_THREE_VALUE = 32'h00000000
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Coprocessor access request
    input wire req_valid,
    input wire req_write,
    input wire [2:0] req_opc1,
    input wire [3:0] req_crn,
    input wire [3:0] req_crm,
    input wire [2:0] req_opc2,
    input wire [1:0] req_priv,
    input wire req_nonsecure,
    // Answer
    output reg rsp_valid,
    output reg rsp_fault,
    output reg rsp_hit,
    output reg [31:0] rsp_data
);

    // ********************************************
    // Decode
    // ********************************************
    function sel_match;
        input [2:0] opc1;
        input [3:0] crn;
        input [3:0] crm;
        input [2:0] opc2;
        input [2:0] want;
        begin
            sel_match = (opc1 == `SEL_OPC1) && (crn == `SEL_CRN) &&
                        (crm == `SEL_CRM) && (opc2 == want);
        end
    endfunction

    wire [31:0] two_word;
    wire [31:0] three_word;
    wire hit_two;
    wire hit_three;
    wire priv_ok;

    attr_two_value u_two (
        .value(two_word)
    );

    attr_three_value #(
        .RESET_VALUE(ATTR_THREE_VALUE)
    ) u_three (
        .value(three_word)
    );

    assign hit_two = sel_match(req_opc1, req_crn, req_crm, req_opc2, `SEL_OPC2_ATTR_TWO);
    assign hit_three = sel_match(req_opc1, req_crn, req_crm, req_opc2, `SEL_OPC2_ATTR_THREE);
    assign priv_ok = (req_priv != `PRIV_USER);

    // ********************************************
    // Answer
    // ********************************************
    // Security state deliberately unused: contents are common to both
    wire unused_ns;
    assign unused_ns = req_nonsecure;

    reg rsp_valid_d;
    reg rsp_fault_d;
    reg rsp_hit_d;
    reg [31:0] rsp_data_d;

    always @*
    begin
        rsp_valid_d = req_valid;
        rsp_hit_d = req_valid & (hit_two | hit_three);
        rsp_fault_d = 1'b0;
        rsp_data_d = 32'h00000000;
        if (req_valid && (hit_two || hit_three))
        begin
            // Writes or unprivileged access fault; no state to disturb
            if (req_write || !priv_ok)
            begin
                rsp_fault_d = 1'b1;
            end
            else if (hit_two)
            begin
                rsp_data_d = two_word;
            end
            else
            begin
                rsp_data_d = three_word;
            end
        end
    end

    always @(posedge clk)
    begin
        if (srst)
        begin
            rsp_valid <= 1'b0;
            rsp_fault <= 1'b0;
            rsp_hit <= 1'b0;
            rsp_data <= 32'h00000000;
        end
        else
        begin
            rsp_valid <= rsp_valid_d;
            rsp_fault <= rsp_fault_d;
            rsp_hit <= rsp_hit_d;
            rsp_data <= rsp_data_d;
        end
    end
endmodule

// ---- testbench/isa_feature_regs_monitor.sv ----
// Purpose: Port checker for isa_feature_regs
// Assumes: One clock, srst sync high
// Notes: Bound below
`timescale 1ns/10ps
module isa_feature_regs_monitor #(
    parameter [31:0] ATTR_THREE_VALUE = 32'h0
) (
    // Clock and reset
    input logic clk,
    input logic srst,
    // Request
    input logic req_valid,
    input logic req_write,
    input logic [2:0] req_opc1,
    input logic [3:0] req_crn,
    input logic [3:0] req_crm,
    input logic [2:0] req_opc2,
    input logic [1:0] req_priv,
    input logic req_nonsecure,
    // Answer
    input logic rsp_valid,
    input logic rsp_fault,
    input logic rsp_hit,
    input logic [31:0] rsp_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire sel = req_valid && req_opc1 == 3'h0 && req_crn == 4'h0 && req_crm == 4'h2;
    wire ok = !req_write && req_priv != 2'h0;
    wire rd = sel && ok && req_opc2 == 3'h1;
    property p_f1; rd |=> rsp_data[31:24] == 8'h13; endproperty
    a_f1: assert property (p_f1) else $error("f1");
    property p_f2; rd |=> rsp_data[23:16] == 8'h11; endproperty
    a_f2: assert property (p_f2) else $error("f2");
    property p_f3; rd |=> rsp_data[15:8] == 8'h21; endproperty
    a_f3: assert property (p_f3) else $error("f3");
    property p_f4; rd |=> rsp_data[7:0] == 8'h11; endproperty
    a_f4: assert property (p_f4) else $error("f4");
    property p_rd; rd |=> rsp_valid && rsp_hit && !rsp_fault; endproperty
    a_rd: assert property (p_rd) else $error("rd");
    property p_t3; sel && ok && req_opc2 == 3'h2 |=> rsp_data == ATTR_THREE_VALUE; endproperty
    a_t3: assert property (p_t3) else $error("t3");
    property p_ft; sel && !ok && req_opc2 inside {3'h1, 3'h2} |=> rsp_fault && rsp_data == 32'h0; endproperty
    a_ft: assert property (p_ft) else $error("ft");
    property p_id; !req_valid |=> !rsp_valid && !rsp_hit && rsp_data == 32'h0; endproperty
    a_id: assert property (p_id) else $error("id");
endmodule
bind isa_feature_regs isa_feature_regs_monitor #(.ATTR_THREE_VALUE(ATTR_THREE_VALUE)) i_mon (.*);

// ---- testbench/isa_feature_regs_tb.sv ----
// Purpose: Random self-checking bench
// Assumes: Answer one cycle after request
// Notes: Second reset mid-run
`timescale 1ns/10ps
module isa_feature_regs_tb;
    localparam [31:0] A3 = 32'h5A3C0F96;
    logic clk, srst, req_valid, req_write, req_nonsecure, rsp_valid, rsp_fault, rsp_hit, h, f;
    logic [2:0] req_opc1, req_opc2;
    logic [3:0] req_crn, req_crm;
    logic [1:0] req_priv;
    logic [31:0] rsp_data, s;
    logic [34:0] ex;
    logic [34:0] exq[$];
    integer n_checks = 0, n_mismatch = 0, i;
    isa_feature_regs #(.ATTR_THREE_VALUE(A3)) i_dut (.*);
    function [31:0] xs(input [31:0] x);
        xs = x ^ (x << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    task check_word(input [34:0] got, input [34:0] exp);
        begin
            n_checks++;
            if (got !== exp)
            begin
                n_mismatch++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // Reference taken from inputs seen at the edge
    always @(posedge clk)
    begin
        h = req_valid && req_opc1 == 3'h0 && req_crn == 4'h0 && req_crm == 4'h2 && req_opc2 inside {3'h1, 3'h2};
        f = h && (req_write || req_priv == 2'h0);
        ex = srst ? 35'h0 : {req_valid, h, f, (h && !f) ? (req_opc2 == 3'h1 ? 32'h13112111 : A3) : 32'h0};
        exq.push_back(ex);
    end
    // Answer of the edge just passed is settled by the falling edge
    always @(negedge clk)
    begin
        if (exq.size() > 0)
            check_word({rsp_valid, rsp_hit, rsp_fault, rsp_data}, exq.pop_front());
    end
    initial
    begin
        #20000;
        n_mismatch++;
        report_and_stop;
    end
    initial
    begin
        s = 32'h3102F04D;
        {srst, req_valid, req_write, req_nonsecure, req_opc1, req_opc2, req_crn, req_crm, req_priv} = 20'h80000;
        repeat (2) @(posedge clk);
        for (i = 0; i < 800; i++)
        begin
            s = xs(s);
            // Bias selectors so half the requests use opcode1 0, c0, c2; opcode2 stays random
            req_valid <= s[0] | s[1];
            req_write <= s[2] & s[3];
            req_opc1 <= s[4] ? 3'h0 : s[7:5];
            req_crn <= s[4] ? 4'h0 : s[11:8];
            req_crm <= s[4] ? 4'h2 : s[15:12];
            req_opc2 <= s[18:16];
            req_priv <= s[20:19];
            req_nonsecure <= s[21];
            srst <= (i == 400);
            @(posedge clk);
        end
        report_and_stop;
    end
endmodule
